// *** bench/dnba_prog_model.sv ***
`default_nettype none
// ************************************************************
// external programmer model on the pgm port
// ************************************************************
module dnba_prog_model (
  input  wire logic       clk,
  output logic            sel,
  output logic            we,
  output logic      [7:0] addr,
  output logic      [7:0] wdata,
  input  wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle: deselected and never writing
  initial begin
    sel   = 1'b0;
    we    = 1'b0;
    addr  = 8'h00;
    wdata = 8'h00;
  end

  // registered read; the address is inverted on release so no stale value lingers
  task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sel  <= 1'b1;
    addr <= a;
    @(posedge clk);
    @(negedge clk);
    d = rdata;
    @(posedge clk);
    sel  <= 1'b0;
    addr <= ~a;
  endtask : read_byte

  // programmer write: one-cycle start pulse, the engine then times it alone
  task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sel   <= 1'b1;
    we    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    sel   <= 1'b0;
    we    <= 1'b0;
    addr  <= ~a;
  endtask : write_byte
endmodule : dnba_prog_model
`default_nettype wire

// *** bench/tb.sv ***
`default_nettype none
`define DNBA_CHK(got, exp, msg) begin cmp_count++; if ((got) !== (exp)) begin miscompares++; \
  $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp); end end
// ************************************************************
// register-level testbench
// ************************************************************
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import dnba_pkg::*;
  localparam int WCYC = 8; // short write time keeps the run brief

  logic       clk, arst_n, sfr_we, sfr_re, pwrt, cprot, flag_clr, wflag;
  logic       pgm_sel, pgm_we;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, pgm_addr, pgm_wdata, pgm_rdata, rv;
  logic [2:0] abort_src;
  int         miscompares, cmp_count;

  dnba_top #(.LARGE_VARIANT(1'b0), .WRITE_CYC(WCYC), .KEY_GAP(2)) i_dut (
    .CORE_CLK(clk), .ARST_N(arst_n), .SFR_ADDR(sfr_addr), .SFR_WE(sfr_we), .SFR_RE(sfr_re),
    .SFR_WDATA(sfr_wdata), .SFR_RDATA(sfr_rdata), .EXTERNAL_RESET_PIN(abort_src[0]),
    .WATCHDOG_TIMEOUT(abort_src[1]), .BROWNOUT_RESET(abort_src[2]), .PWRT_ACTIVE(pwrt),
    .CODE_PROTECT(cprot), .PGM_SEL(pgm_sel), .PGM_WE(pgm_we), .PGM_ADDR(pgm_addr),
    .PGM_WDATA(pgm_wdata), .PGM_RDATA(pgm_rdata), .FLAG_CLR(flag_clr), .WRITE_COMPLETE_FLAG(wflag));

  dnba_prog_model i_prog (.clk(clk), .sel(pgm_sel), .we(pgm_we), .addr(pgm_addr),
    .wdata(pgm_wdata), .rdata(pgm_rdata));

  // free-running core clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // register write: one-cycle strobe, dropped at the next edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_we    <= 1'b1;
    @(posedge clk);
    sfr_we    <= 1'b0;
  endtask : wr

  // register read: data is taken once it has settled after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_re   <= 1'b1;
    @(posedge clk);
    sfr_re   <= 1'b0;
    @(negedge clk);
    d = sfr_rdata;
  endtask : rd

  // load buffers, unlock at the exact key spacing, then set the strobes
  task automatic start_write(input logic [7:0] a, input logic [7:0] d, input logic [7:0] pre,
                             input logic [7:0] ctl);
    wr(ADDR_CTL, pre);
    wr(ADDR_DATA, d);
    wr(ADDR_PTR, a);
    wr(ADDR_KEY, KEY_FIRST);
    wr(ADDR_KEY, KEY_SECOND);
    wr(ADDR_CTL, ctl);
  endtask : start_write

  // bounded wait on the completion flag
  task automatic wait_flag();
    int n;
    n = 0;
    while (wflag !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    `DNBA_CHK(wflag, 1'b1, "completion flag")
  endtask : wait_flag

  task automatic ee_read(input logic [7:0] a, output logic [7:0] d);
    wr(ADDR_PTR, a);
    wr(ADDR_CTL, 8'h01);
    rd(ADDR_DATA, d);
  endtask : ee_read

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  // watchdog: all tests need well under 3000 cycles
  initial begin
    #(100 * 6000);
    miscompares++;
    $display("mismatch at %0t: run hung", $time);
    report_and_stop();
  end

  initial begin
    {arst_n, sfr_we, sfr_re, pwrt, cprot, flag_clr} = '0;
    {sfr_addr, sfr_wdata, abort_src} = '0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    // reset values, unimplemented bits, key port
    rd(ADDR_CTL, rv);  `DNBA_CHK(rv, 8'h00, "ctl after reset")
    rd(ADDR_KEY, rv);  `DNBA_CHK(rv, 8'h00, "key port")
    wr(ADDR_CTL, 8'hF4);
    rd(ADDR_CTL, rv);  `DNBA_CHK(rv, 8'h04, "ctl upper bits")
    $display("test reset_values done");
    // timed write while code protected
    @(posedge clk) cprot <= 1'b1;
    start_write(8'h05, 8'h3C, 8'h04, 8'h06);
    rd(ADDR_CTL, rv);  `DNBA_CHK(rv, 8'h06, "strobe held")
    wait_flag();
    rd(ADDR_CTL, rv);  `DNBA_CHK(rv, 8'h04, "strobe cleared, permit kept")
    ee_read(8'h05, rv); `DNBA_CHK(rv, 8'h3C, "read back")
    `DNBA_CHK(wflag, 1'b1, "flag sticky")
    wr(ADDR_DATA, 8'h11);
    rd(ADDR_DATA, rv); `DNBA_CHK(rv, 8'h11, "buffer written")
    i_prog.read_byte(8'h05, rv); `DNBA_CHK(rv, 8'h00, "programmer blocked")
    i_prog.write_byte(8'h05, 8'h66);
    repeat (10) @(posedge clk);
    cprot <= 1'b0;
    i_prog.read_byte(8'h05, rv); `DNBA_CHK(rv, 8'h3C, "programmer open, write refused")
    @(posedge clk) flag_clr <= 1'b1;
    @(posedge clk) flag_clr <= 1'b0;
    @(negedge clk);    `DNBA_CHK(wflag, 1'b0, "flag cleared")
    // unprotected programmer write lands but raises no cpu completion flag
    i_prog.write_byte(8'h20, 8'h42);
    repeat (10) @(posedge clk);
    `DNBA_CHK(wflag, 1'b0, "no flag for programmer write")
    i_prog.read_byte(8'h20, rv); `DNBA_CHK(rv, 8'h42, "programmer write stored")
    // both strobes: the read lands first so the old byte is written back
    start_write(8'h05, 8'h99, 8'h04, 8'h07);
    wait_flag();
    ee_read(8'h05, rv); `DNBA_CHK(rv, 8'h3C, "read before write")
    ee_read(8'h85, rv); `DNBA_CHK(rv, 8'h00, "top address bit decoded")
    @(posedge clk) flag_clr <= 1'b1;
    @(posedge clk) flag_clr <= 1'b0;
    $display("test write_read done");
    // refused starts: no permit, broken key spacing, power-up timer
    start_write(8'h05, 8'h77, 8'h00, 8'h06);
    rd(ADDR_CTL, rv);  `DNBA_CHK(rv, 8'h04, "no permit")
    wr(ADDR_KEY, KEY_FIRST);
    wr(ADDR_PTR, 8'h05);
    wr(ADDR_KEY, KEY_SECOND);
    wr(ADDR_CTL, 8'h06);
    rd(ADDR_CTL, rv);  `DNBA_CHK(rv, 8'h04, "broken key")
    @(posedge clk) pwrt <= 1'b1;
    start_write(8'h05, 8'h77, 8'h04, 8'h06);
    rd(ADDR_CTL, rv);  `DNBA_CHK(rv, 8'h04, "power-up timer")
    @(posedge clk) pwrt <= 1'b0;
    repeat (12) @(posedge clk);
    `DNBA_CHK(wflag, 1'b0, "no completion")
    ee_read(8'h05, rv); `DNBA_CHK(rv, 8'h3C, "array untouched")
    $display("test refusals done");
    // each abort source cuts a write short
    for (int i = 0; i < 3; i++) begin
      start_write(8'h10 + 8'(i), 8'hA0 + 8'(i), 8'h04, 8'h06);
      repeat (3) @(posedge clk);
      abort_src[i] <= 1'b1;
      @(posedge clk) abort_src[i] <= 1'b0;
      rd(ADDR_CTL, rv);  `DNBA_CHK(rv, 8'h08, "abort flag")
      rd(ADDR_PTR, rv);  `DNBA_CHK(rv, 8'h10 + 8'(i), "pointer kept")
      rd(ADDR_DATA, rv); `DNBA_CHK(rv, 8'hA0 + 8'(i), "data kept")
      `DNBA_CHK(wflag, 1'b0, "no completion on abort")
    end
    start_write(8'h12, 8'h5A, 8'h0C, 8'h0E);
    wait_flag();
    rd(ADDR_CTL, rv);  `DNBA_CHK(rv, 8'h04, "abort flag zero on completion")
    ee_read(8'h12, rv); `DNBA_CHK(rv, 8'h5A, "retry stored")
    $display("test aborts done");
    report_and_stop();
  end
endmodule : tb
`default_nettype wire

// *** src/dnba_array.sv ***
`default_nettype none
// ************************************************************
// storage array with timed erase-then-program engine
// ************************************************************
module dnba_array import dnba_pkg::*; #(
  parameter int DEPTH     = SMALL_DEPTH,
  parameter int WRITE_CYC = WRITE_CYC_DEF
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [7:0] rd_addr,
  output logic      [7:0] rd_data,
  input  wire logic [7:0] rd2_addr,
  output logic      [7:0] rd2_data,
  input  wire logic       start,
  input  wire logic [7:0] wr_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_valid,
  input  wire logic       abort,
  output logic            busy,
  output logic            done
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(WRITE_CYC + 1);
  localparam logic [CW-1:0] ERASE_END = CW'(WRITE_CYC / 2 - 1);
  localparam logic [CW-1:0] WRITE_END = CW'(WRITE_CYC - 1);
  localparam logic [CW-1:0] CNT_ONE   = CW'(1);

  logic [7:0]    mem [DEPTH];
  dnba_eng_t     state_r;
  logic [CW-1:0] cnt_r;
  logic [AW-1:0] addr_r;
  logic [7:0]    data_r;
  logic          valid_r;

  assign rd_data  = mem[rd_addr[AW-1:0]];
  assign rd2_data = mem[rd2_addr[AW-1:0]];
  assign busy     = (state_r != ENG_IDLE);
  assign done     = (state_r == ENG_PROG) && (cnt_r == WRITE_END);

  // timer owns the write duration; only the abort input or arst_n can cut it short
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ENG_IDLE;
      cnt_r   <= '0;
      addr_r  <= '0;
      data_r  <= ZERO_BYTE;
      valid_r <= 1'b0;
    end else if (abort) begin
      state_r <= ENG_IDLE;
      cnt_r   <= '0;
    end else begin
      unique case (state_r)
        ENG_IDLE: begin
          if (start) begin
            state_r <= ENG_ERASE;
            cnt_r   <= '0;
            addr_r  <= wr_addr[AW-1:0];
            data_r  <= wr_data;
            valid_r <= wr_valid;
          end
        end
        ENG_ERASE: begin
          cnt_r <= cnt_r + CNT_ONE;
          if (cnt_r == ERASE_END) begin
            state_r <= ENG_PROG;
          end
        end
        ENG_PROG: begin
          cnt_r <= cnt_r + CNT_ONE;
          if (done) begin
            state_r <= ENG_IDLE;
            cnt_r   <= '0;
          end
        end
        default: state_r <= ENG_IDLE;
      endcase
    end
  end

  // erase lands at the end of the erase phase, new byte at the end of the write
  always_ff @(posedge clk) begin
    if (!abort && valid_r && state_r == ENG_ERASE && cnt_r == ERASE_END) begin
      mem[addr_r] <= ERASED_BYTE;
    end else if (!abort && valid_r && done) begin
      mem[addr_r] <= data_r;
    end
  end

  a_erase_first: assert property (@(posedge clk) disable iff (!arst_n)
    state_r == ENG_ERASE && cnt_r == ERASE_END && valid_r && !abort |=> mem[addr_r] == ERASED_BYTE)
    else $error("location not erased before program");

  a_done_stores: assert property (@(posedge clk) disable iff (!arst_n)
    done && valid_r && !abort |=> mem[addr_r] == $past(data_r) && state_r == ENG_IDLE)
    else $error("terminal count did not store byte");
endmodule : dnba_array
`default_nettype wire

// *** src/dnba_pkg.sv ***
`default_nettype none
// ************************************************************
// shared constants for the data nonvolatile byte access block
// ************************************************************
package dnba_pkg;
  // special function register offsets on the cpu register port
  localparam logic [7:0] ADDR_DATA = 8'h9A;
  localparam logic [7:0] ADDR_PTR  = 8'h9B;
  localparam logic [7:0] ADDR_CTL  = 8'h9C;
  localparam logic [7:0] ADDR_KEY  = 8'h9D;

  // control register field positions
  localparam int BIT_RD     = 0;
  localparam int BIT_WR     = 1;
  localparam int BIT_PERMIT = 2;
  localparam int BIT_ABORT  = 3;
  localparam logic [3:0] CTL_UPPER_ZERO = 4'h0;

  // data values
  localparam logic [7:0] KEY_FIRST   = 8'h55;
  localparam logic [7:0] KEY_SECOND  = 8'hAA;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] ZERO_BYTE   = 8'h00;

  // array sizes of the two variants
  localparam int SMALL_DEPTH = 128;
  localparam int LARGE_DEPTH = 256;

  // timing: write time is a plain default, the cycles derive from it
  localparam int CLK_PERIOD_NS = 100;
  localparam int WRITE_TIME_US = 4000;
  localparam int WRITE_CYC_DEF = (WRITE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int KEY_GAP_DEF   = 2;

  typedef enum logic [1:0] {
    KEY_IDLE       = 2'b00,
    KEY_SAW_FIRST  = 2'b01,
    KEY_ARMED      = 2'b10
  } dnba_key_t;

  typedef enum logic [1:0] {
    ENG_IDLE  = 2'b00,
    ENG_ERASE = 2'b01,
    ENG_PROG  = 2'b10
  } dnba_eng_t;
endpackage : dnba_pkg
`default_nettype wire

// *** src/dnba_top.sv ***
`default_nettype none
// ************************************************************
// data nonvolatile byte access: cpu register front end
// ************************************************************
// Summary of operation
// - 8-bit data buffer and separate address pointer register reach the array.
// - array is 128 bytes (0h-7Fh) or 256 bytes (0h-FFh) by variant.
// - each byte write erases the location first, then programs the byte.
// - internal timer sets write duration; write strobe stays set until it ends.
// - code protect blocks the programmer port but never cpu access.
// - small variant decodes the top address bit; software keeps it zero.
// - control register holds four bits; upper four read as zero.
// - software only sets read and write strobes; hardware clears them.
// - writes allowed only with write permit set; permit clears at power-up.
// - abort flag sets when a reset cuts a write short.
// - abort reset keeps data buffer and address pointer for a retry.
// - write complete flag sets on finish; only software clears it.
// - unlock key port stores nothing and reads as zero.
// - read strobe loads the addressed byte next cycle and clears itself.
// - data buffer holds a read byte until next read or software write.
// - write starts only after 55h, AAh, strobe set at exact spacing.
// - strobe refused without permit; clearing permit mid-write does not stop it.
// - power-up timer running blocks any array write.
module dnba_top import dnba_pkg::*; #(
  parameter bit LARGE_VARIANT = 1'b0,
  parameter int WRITE_CYC     = WRITE_CYC_DEF,
  parameter int KEY_GAP       = KEY_GAP_DEF
) (
  input  wire logic       CORE_CLK,
  input  wire logic       ARST_N,
  input  wire logic [7:0] SFR_ADDR,
  input  wire logic       SFR_WE,
  input  wire logic       SFR_RE,
  input  wire logic [7:0] SFR_WDATA,
  output logic      [7:0] SFR_RDATA,
  input  wire logic       EXTERNAL_RESET_PIN,
  input  wire logic       WATCHDOG_TIMEOUT,
  input  wire logic       BROWNOUT_RESET,
  input  wire logic       PWRT_ACTIVE,
  input  wire logic       CODE_PROTECT,
  input  wire logic       PGM_SEL,
  input  wire logic       PGM_WE,
  input  wire logic [7:0] PGM_ADDR,
  input  wire logic [7:0] PGM_WDATA,
  output logic      [7:0] PGM_RDATA,
  input  wire logic       FLAG_CLR,
  output logic            WRITE_COMPLETE_FLAG
);
  localparam int DEPTH = LARGE_VARIANT ? LARGE_DEPTH : SMALL_DEPTH;

  // ************************************************************
  // decode and state
  // ************************************************************
  logic [7:0] data_r;
  logic [7:0] addr_r;
  logic       rd_r;
  logic       wr_r;
  logic       permit_r;
  logic       abort_flag_r;
  logic       flag_r;
  logic       pgm_own_r;
  logic [7:0] rdata_r;
  logic [7:0] pgm_rdata_r;

  logic       rst_evt;
  logic       we_ok;
  logic       ctl_wr;
  logic       arm_ok;
  logic       pgm_ok;
  logic       cpu_start;
  logic       pgm_start;
  logic       eng_start;
  logic       eng_busy;
  logic       eng_done;
  logic [7:0] rd_byte;
  logic [7:0] pgm_byte;

  // small variant: top address bit set falls outside the array
  function automatic logic in_range(input logic [7:0] a);
    in_range = LARGE_VARIANT || !a[7];
  endfunction : in_range

  // the resets that may cut a write short all behave alike here
  assign rst_evt = EXTERNAL_RESET_PIN || WATCHDOG_TIMEOUT || BROWNOUT_RESET;
  assign we_ok   = SFR_WE && !rst_evt;
  assign ctl_wr  = we_ok && SFR_ADDR == ADDR_CTL;

  // programmer is shut out entirely while code protect is on
  assign pgm_ok    = PGM_SEL && !CODE_PROTECT;
  assign cpu_start = wr_r && !rd_r && !eng_busy && !pgm_own_r;
  assign pgm_start = pgm_ok && PGM_WE && !eng_busy && !wr_r && !rst_evt;
  assign eng_start = (cpu_start || pgm_start) && !PWRT_ACTIVE;

  // ************************************************************
  // storage and key sequencer
  // ************************************************************
  dnba_array #(
    .DEPTH     (DEPTH),
    .WRITE_CYC (WRITE_CYC)
  ) u_array (
    .clk      (CORE_CLK),
    .arst_n   (ARST_N),
    .rd_addr  (addr_r),
    .rd_data  (rd_byte),
    .rd2_addr (PGM_ADDR),
    .rd2_data (pgm_byte),
    .start    (eng_start),
    .wr_addr  (cpu_start ? addr_r : PGM_ADDR),
    .wr_data  (cpu_start ? data_r : PGM_WDATA),
    .wr_valid (cpu_start ? in_range(addr_r) : in_range(PGM_ADDR)),
    .abort    (rst_evt),
    .busy     (eng_busy),
    .done     (eng_done)
  );

  dnba_unlock #(
    .KEY_GAP (KEY_GAP)
  ) u_unlock (
    .clk     (CORE_CLK),
    .arst_n  (ARST_N),
    .clear   (rst_evt),
    .sfr_we  (we_ok),
    .key_sel (SFR_ADDR == ADDR_KEY),
    .wdata   (SFR_WDATA),
    .arm_ok  (arm_ok)
  );

  // ************************************************************
  // data buffer and address pointer
  // ************************************************************
  // neither is touched by an abort reset so software can retry
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      data_r <= ZERO_BYTE;
    end else if (rd_r && !rst_evt) begin
      data_r <= in_range(addr_r) ? rd_byte : ZERO_BYTE;
    end else if (we_ok && SFR_ADDR == ADDR_DATA) begin
      data_r <= SFR_WDATA;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      addr_r <= ZERO_BYTE;
    end else if (we_ok && SFR_ADDR == ADDR_PTR) begin
      addr_r <= SFR_WDATA;
    end
  end

  // ************************************************************
  // control register
  // ************************************************************
  // read strobe lives exactly one cycle; a zero write cannot clear it
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rd_r <= 1'b0;
    end else if (rst_evt || rd_r) begin
      rd_r <= 1'b0;
    end else if (ctl_wr && SFR_WDATA[BIT_RD]) begin
      rd_r <= 1'b1;
    end
  end

  // write strobe: set only in the unlock slot with permit held beforehand
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wr_r <= 1'b0;
    end else if (rst_evt || (eng_done && !pgm_own_r)) begin
      wr_r <= 1'b0;
    end else if (ctl_wr && SFR_WDATA[BIT_WR] && arm_ok && permit_r && !PWRT_ACTIVE) begin
      wr_r <= 1'b1;
    end
  end

  // permit is never cleared by the write engine itself
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      permit_r <= 1'b0;
    end else if (rst_evt) begin
      permit_r <= 1'b0;
    end else if (ctl_wr) begin
      permit_r <= SFR_WDATA[BIT_PERMIT];
    end
  end

  // abort flag: reset during a write wins over completion and software
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      abort_flag_r <= 1'b0;
    end else if (rst_evt && wr_r) begin
      abort_flag_r <= 1'b1;
    end else if (eng_done && !pgm_own_r && !rst_evt) begin
      abort_flag_r <= 1'b0;
    end else if (ctl_wr) begin
      abort_flag_r <= SFR_WDATA[BIT_ABORT];
    end
  end

  // who owns the running engine, so programmer writes raise no cpu flags
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pgm_own_r <= 1'b0;
    end else if (eng_done || rst_evt) begin
      pgm_own_r <= 1'b0;
    end else if (pgm_start && !PWRT_ACTIVE) begin
      pgm_own_r <= 1'b1;
    end
  end

  // completion flag: set wins over a clear in the same cycle
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      flag_r <= 1'b0;
    end else if (eng_done && !pgm_own_r && !rst_evt) begin
      flag_r <= 1'b1;
    end else if (FLAG_CLR) begin
      flag_r <= 1'b0;
    end
  end

  // ************************************************************
  // read back
  // ************************************************************
  // key port and unmapped offsets return zero
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_r <= ZERO_BYTE;
    end else if (SFR_RE) begin
      unique case (SFR_ADDR)
        ADDR_DATA: rdata_r <= data_r;
        ADDR_PTR:  rdata_r <= addr_r;
        ADDR_CTL:  rdata_r <= {CTL_UPPER_ZERO, abort_flag_r, permit_r, wr_r, rd_r};
        default:   rdata_r <= ZERO_BYTE;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pgm_rdata_r <= ZERO_BYTE;
    end else begin
      pgm_rdata_r <= (pgm_ok && in_range(PGM_ADDR)) ? pgm_byte : ZERO_BYTE;
    end
  end

  assign SFR_RDATA           = rdata_r;
  assign PGM_RDATA           = pgm_rdata_r;
  assign WRITE_COMPLETE_FLAG = flag_r;

  // ************************************************************
  // checks
  // ************************************************************
  sequence s_abort_write;
    rst_evt && wr_r;
  endsequence

  sequence s_both_strobes;
    ctl_wr && SFR_WDATA[BIT_RD] && SFR_WDATA[BIT_WR] && arm_ok && permit_r && !PWRT_ACTIVE && !rd_r;
  endsequence

  a_read_one_cycle: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    rd_r |=> !rd_r)
    else $error("read strobe held past one cycle");

  a_read_loads_buf: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    rd_r && !rst_evt && in_range(addr_r) |=> data_r == $past(rd_byte))
    else $error("read byte not in data buffer");

  a_ctl_upper_zero: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    SFR_RE && SFR_ADDR == ADDR_CTL |=> SFR_RDATA[7:4] == CTL_UPPER_ZERO)
    else $error("control upper bits not zero");

  a_key_reads_zero: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    SFR_RE && SFR_ADDR == ADDR_KEY |=> SFR_RDATA == ZERO_BYTE)
    else $error("key port read not zero");

  a_write_permit: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    $rose(wr_r) |-> $past(permit_r) && $past(arm_ok))
    else $error("write strobe set without permit or unlock");

  a_done_clears_wr: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    eng_done && !pgm_own_r && !rst_evt |=> !wr_r && flag_r)
    else $error("completion did not clear strobe and raise flag");

  a_wr_holds: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    wr_r && !eng_done && !rst_evt |=> wr_r)
    else $error("write strobe dropped before timer end");

  a_flag_sticky: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    flag_r && !FLAG_CLR |=> flag_r)
    else $error("completion flag lost without clear");

  a_abort_sets_err: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    s_abort_write |=> abort_flag_r && !wr_r)
    else $error("aborted write did not set abort flag");

  a_abort_keeps: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    s_abort_write |=> $stable(addr_r) && $stable(data_r))
    else $error("abort reset disturbed buffer or pointer");

  a_pwrt_blocks: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    PWRT_ACTIVE && !eng_busy |=> !eng_busy)
    else $error("write started under power-up timer");

  a_read_first: assert property (@(posedge CORE_CLK) disable iff (!ARST_N || rst_evt)
    s_both_strobes |=> rd_r && wr_r && !eng_start ##1 !rd_r && wr_r)
    else $error("write not ordered after read");
endmodule : dnba_top
`default_nettype wire

// *** src/dnba_unlock.sv ***
`default_nettype none
// ************************************************************
// unlock key sequencer
// ************************************************************
module dnba_unlock import dnba_pkg::*; #(
  parameter int KEY_GAP = KEY_GAP_DEF
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       clear,
  input  wire logic       sfr_we,
  input  wire logic       key_sel,
  input  wire logic [7:0] wdata,
  output logic            arm_ok
);
  localparam int GW = $clog2(KEY_GAP + 2);
  localparam logic [GW-1:0] GAP_ONE = GW'(1);
  localparam logic [GW-1:0] GAP_END = GW'(KEY_GAP);

  dnba_key_t     state_r;
  logic [GW-1:0] gap_r;

  // each step must land exactly KEY_GAP cycles after the previous one
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= KEY_IDLE;
      gap_r   <= '0;
    end else if (clear) begin
      state_r <= KEY_IDLE;
      gap_r   <= '0;
    end else if (sfr_we) begin
      gap_r <= GAP_ONE;
      if (key_sel && wdata == KEY_FIRST) begin
        state_r <= KEY_SAW_FIRST;
      end else if (key_sel && wdata == KEY_SECOND && state_r == KEY_SAW_FIRST && gap_r == GAP_END) begin
        state_r <= KEY_ARMED;
      end else begin
        state_r <= KEY_IDLE;
      end
    end else if (state_r != KEY_IDLE) begin
      // a missed slot breaks the sequence for good
      if (gap_r == GAP_END) begin
        state_r <= KEY_IDLE;
      end else begin
        gap_r <= gap_r + GAP_ONE;
      end
    end
  end

  // strobe write is honoured only in the exact slot after the second key
  assign arm_ok = (state_r == KEY_ARMED) && (gap_r == GAP_END);

  sequence s_key_second;
    sfr_we && key_sel && wdata == KEY_SECOND && state_r == KEY_SAW_FIRST;
  endsequence

  a_arm_after_key: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(state_r == KEY_ARMED) |-> $past(sfr_we && key_sel && wdata == KEY_SECOND))
    else $error("unlock armed without second key");

  a_key_pair_arms: assert property (@(posedge clk) disable iff (!arst_n || clear)
    (s_key_second and (gap_r == GAP_END)) |=> state_r == KEY_ARMED)
    else $error("timed key pair did not arm");
endmodule : dnba_unlock
`default_nettype wire
